// >>> logic/tdl_cmd_core.sv
// Density mode and load/unload command handling behind an APB register file
`timescale 1ns/1ps
module tdl_cmd_core (
   input  wire logic        clk_sys,       // System clock
   input  wire logic        rst,           // Async reset, active high
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB write
   input  wire logic [7:0]  paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error, unmapped address
   input  wire logic [1:0]  drive_model,   // Drive capacity model
   input  wire logic [1:0]  cart_type,     // Installed cartridge grade
   input  wire logic        cart_removed,  // Pulse: cartridge taken out
   input  wire logic        parity_err,    // Bus or internal parity fault
   output logic             probe_req,     // Format probe in progress
   output logic      [7:0]  probe_code,    // Format being probed
   input  wire logic        probe_done,    // Pulse: probe finished
   input  wire logic        probe_hit,     // Probe found the format
   output logic             move_req,      // Tape move in progress
   output logic             move_eot,      // Move target is end of tape
   input  wire logic        move_done,     // Pulse: move finished
   output logic             panel_led      // Front panel light
);
   typedef enum logic [1:0] {S_IDLE, S_PROBE, S_POS} tdl_st_t;
   typedef struct packed {
      tdl_st_t     st;
      logic [31:0] cdb_lo;
      logic [15:0] cdb_hi;
      logic [7:0]  dens_req;
      logic [7:0]  dens_act;
      logic [7:0]  dens_rep;
      logic        expl;
      logic [7:0]  stat;
      logic [3:0]  sense;
      logic        done;
      logic        led;
      logic        loaded;
      logic        at_bot;
      logic        ua;
      logic [1:0]  pidx;
      logic        preq;
      logic [7:0]  pcode;
      logic        pos_go;
      logic        retension_request;
      logic        early;
      logic        ldsel;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } tdl_core_t;

   tdl_core_t   q, n;
   logic        start;
   logic        acc;
   logic        pos_done;
   logic [7:0]  impl_code;
   logic        impl_bad;
   logic        model_bad;
   logic        cart_bad;
   logic        cdb_resv;
   tdl_pkg::tdl_op_t op;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic tdl_core_t fin(input tdl_core_t s, input logic [3:0] k);
      fin       = s;
      fin.st    = S_IDLE;
      fin.done  = 1'b1;
      fin.sense = k;
      fin.stat  = (k == tdl_pkg::SK_NONE) ? tdl_pkg::ST_GOOD : tdl_pkg::ST_CHECK;
      fin.preq  = 1'b0;
   endfunction

   tdl_dens_chk u_dens (
      .model     (drive_model),
      .cart      (cart_type),
      .code      (q.dens_act),
      .impl_code (impl_code),
      .impl_bad  (impl_bad),
      .model_bad (model_bad),
      .cart_bad  (cart_bad)
   );

   tdl_pos_seq u_pos (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .start     (q.pos_go),
      .retension_request     (q.retension_request),
      .move_done (move_done),
      .move_req  (move_req),
      .move_eot  (move_eot),
      .done      (pos_done)
   );

   assign acc      = psel && penable && q.pready;
   assign op       = tdl_pkg::tdl_op_t'(pwdata[1:0]);
   // Mode sense block with any reserved byte or bit set is invalid
   assign cdb_resv = (q.cdb_lo[31:8] != 24'h000000) || (q.cdb_hi[13:10] != 4'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      n        = q;
      start    = 1'b0;
      n.pos_go = 1'b0;
      // Registered read data gives one access cycle per transfer
      if (psel && !penable) begin
         n.pready  = 1'b1;
         n.pslverr = 1'b0;
         unique case (paddr)
            tdl_pkg::A_CDB_LO: n.prdata = q.cdb_lo;
            tdl_pkg::A_CDB_HI: n.prdata = {16'h0000, q.cdb_hi};
            tdl_pkg::A_CMD:    n.prdata = {31'h0, q.st != S_IDLE};
            tdl_pkg::A_STAT:   n.prdata = {15'h0, q.done, 4'h0, q.sense, q.stat};
            tdl_pkg::A_DENS:   n.prdata = {24'h0, q.dens_req};
            tdl_pkg::A_DESC0:  n.prdata = {tdl_pkg::NBLK_ZERO, q.dens_rep};
            tdl_pkg::A_DESC1:  n.prdata = tdl_pkg::DESC1_VAL;
            tdl_pkg::A_STATE:  n.prdata = {16'h0, q.dens_act, 3'h0, q.at_bot,
                                           q.expl, q.ua, q.loaded, q.led};
            default: begin
               n.prdata  = 32'h00000000;
               n.pslverr = 1'b1;
            end
         endcase
      end
      if (acc) begin
         n.pready  = 1'b0;
         n.pslverr = 1'b0;
         if (pwrite && !q.pslverr) begin
            unique case (paddr)
               tdl_pkg::A_CDB_LO: n.cdb_lo = pwdata;
               tdl_pkg::A_CDB_HI: n.cdb_hi = pwdata[15:0];
               tdl_pkg::A_DENS:   n.dens_req = pwdata[7:0];
               tdl_pkg::A_CMD:    start = 1'b1;
               default: ;
            endcase
         end
      end

      // Command start; a new command is taken only in S_IDLE, otherwise busy status
      if (start && q.st != S_IDLE) begin
         n.done  = 1'b1;
         n.stat  = tdl_pkg::ST_BUSY;
         n.sense = tdl_pkg::SK_NONE;
      end else if (start) begin
         n.done = 1'b0;
         unique case (op)
            tdl_pkg::OP_CDB: begin
               if (q.cdb_lo[7:0] == tdl_pkg::OPC_LOAD) begin
                  if (q.cdb_lo[tdl_pkg::B_EARLY] && q.cdb_hi[tdl_pkg::B_LINK]) begin
                     n = fin(n, tdl_pkg::SK_ILL);
                  end else begin
                     n.st     = S_POS;
                     n.pos_go = 1'b1;
                     n.at_bot = 1'b0;
                     n.retension_request  = q.cdb_hi[tdl_pkg::B_RETENSION_REQUEST];
                     n.ldsel  = q.cdb_hi[tdl_pkg::B_LDSEL];
                     n.early  = q.cdb_lo[tdl_pkg::B_EARLY];
                     if (q.cdb_lo[tdl_pkg::B_EARLY]) begin
                        n       = fin(n, tdl_pkg::SK_NONE);
                        n.st    = S_POS;
                     end
                  end
               end else if (q.cdb_lo[7:0] == tdl_pkg::OPC_MSENSE) begin
                  if (parity_err) begin
                     n = fin(n, tdl_pkg::SK_HW);
                  end else if (cdb_resv) begin
                     n = fin(n, tdl_pkg::SK_ILL);
                  end else if (q.ua) begin
                     n    = fin(n, tdl_pkg::SK_UA);
                     n.ua = 1'b0;
                  end else begin
                     n = fin(n, tdl_pkg::SK_NONE);
                  end
               end else begin
                  n = fin(n, tdl_pkg::SK_ILL);
               end
            end
            tdl_pkg::OP_READ: begin
               n.st     = S_PROBE;
               n.preq   = 1'b1;
               n.pidx   = 2'h0;
               // Explicit mode probes only the selected format
               n.pcode  = q.expl ? q.dens_act : tdl_pkg::search_code(2'h0);
               n.at_bot = 1'b0;
            end
            tdl_pkg::OP_WRITE: begin
               n.at_bot = 1'b0;
               if (q.expl && model_bad) begin
                  n = fin(n, tdl_pkg::SK_ILL);
               end else if (q.expl && cart_bad) begin
                  n = fin(n, tdl_pkg::SK_WP);
               end else if (!q.expl && impl_bad) begin
                  n = fin(n, tdl_pkg::SK_ILL);
               end else begin
                  n          = fin(n, tdl_pkg::SK_NONE);
                  n.dens_act = q.expl ? q.dens_act : impl_code;
                  n.dens_rep = n.dens_act;
                  n.expl     = 1'b1;
               end
            end
            tdl_pkg::OP_MSEL: begin
               if (!tdl_pkg::dens_known(q.dens_req)) begin
                  n = fin(n, tdl_pkg::SK_ILL);
               end else begin
                  // Reported code is left alone until a read or write
                  n          = fin(n, tdl_pkg::SK_NONE);
                  n.dens_act = q.dens_req;
                  n.expl     = (q.dens_req != tdl_pkg::DENS_IMPL);
               end
            end
         endcase
      end

      // Format probing
      if (q.st == S_PROBE && probe_done) begin
         if (probe_hit) begin
            n          = fin(n, tdl_pkg::SK_NONE);
            n.dens_act = q.pcode;
            n.dens_rep = q.pcode;
            n.expl     = 1'b1;
         end else if (!q.expl && q.pidx != 2'h3) begin
            n.pidx  = q.pidx + 2'h1;
            n.pcode = tdl_pkg::search_code(q.pidx + 2'h1);
         end else begin
            n = fin(n, tdl_pkg::SK_BLANK);
         end
      end

      // Positioning finished at BOT
      if (q.st == S_POS && pos_done) begin
         n.st     = S_IDLE;
         n.at_bot = 1'b1;
         n.led    = q.ldsel;
         n.loaded = q.ldsel;
         if (!q.early) begin
            n       = fin(n, tdl_pkg::SK_NONE);
            n.st    = S_IDLE;
         end
      end

      // Removal raises attention unless unloaded at BOT; set beats clear
      if (cart_removed && (q.loaded || !q.at_bot)) begin
         n.ua = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q          <= '0;
         q.st       <= S_IDLE;
         q.dens_req <= tdl_pkg::DENS_RST;
         q.dens_act <= tdl_pkg::DENS_RST;
         q.dens_rep <= tdl_pkg::DENS_RST;
         q.ua       <= tdl_pkg::UA_RST;
      end else begin
         q <= n;
      end
   end

   assign prdata     = q.prdata;
   assign pready     = q.pready;
   assign pslverr    = q.pslverr;
   assign probe_req  = q.preq;
   assign probe_code = q.pcode;
   assign panel_led  = q.led;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic ld_ok;
   assign ld_ok = start && q.st == S_IDLE && op == tdl_pkg::OP_CDB &&
                  q.cdb_lo[7:0] == tdl_pkg::OPC_LOAD && !q.cdb_hi[tdl_pkg::B_LINK];

   sequence s_desc1_rd;
      psel && !penable && !pwrite && paddr == tdl_pkg::A_DESC1;
   endsequence

   chk_blk_len: assert property (s_desc1_rd |=> pready && prdata == 32'h00020000)
      else $error("block length word wrong");
   chk_nblk_zero: assert property (psel && !penable && paddr == tdl_pkg::A_DESC0
      |=> prdata[31:8] == 24'h000000)
      else $error("block count not zero");
   chk_early_link: assert property (start && q.st == S_IDLE && op == tdl_pkg::OP_CDB
      && q.cdb_lo[7:0] == 8'h1b && q.cdb_lo[8] && q.cdb_hi[8]
      |=> done_ill(q.done, q.stat, q.sense))
      else $error("early plus link not refused");
   chk_early_stat: assert property (ld_ok && q.cdb_lo[8]
      |=> q.done && q.stat == 8'h00 && q.st == S_POS)
      else $error("early status not given at start");
   chk_hold_stat: assert property (q.st == S_POS && !q.early |-> !q.done)
      else $error("status given before positioning ended");
   chk_led_set: assert property (q.st == S_POS && pos_done
      |=> panel_led == $past(q.ldsel) && q.at_bot)
      else $error("panel light not following load select");
   chk_rep_hold: assert property (start && q.st == S_IDLE && op == tdl_pkg::OP_MSEL
      |=> $stable(q.dens_rep))
      else $error("reported density changed on select");
   chk_search_ord: assert property (q.st == S_PROBE && !q.expl && probe_done
      && !probe_hit && probe_code == 8'h10 |=> probe_code == 8'h0f && probe_req)
      else $error("format search order wrong");
   chk_ua_load: assert property (cart_removed && q.loaded |=> q.ua)
      else $error("removal after load missed");
   chk_blank_chk: assert property (q.st == S_PROBE && q.expl && probe_done
      && !probe_hit |=> q.done && q.sense == 4'h8 && q.stat == 8'h02)
      else $error("explicit read miss not blank check");

   // Values come in as arguments so the check sees the sampled ones
   function automatic logic done_ill(input logic d, input logic [7:0] s, input logic [3:0] k);
      done_ill = d && s == 8'h02 && k == 4'h5;
   endfunction
endmodule // tdl_cmd_core

// >>> logic/tdl_dens_chk.sv
// Density choice and legality checks for writes
`timescale 1ns/1ps
module tdl_dens_chk (
   input  wire logic [1:0] model,      // Drive capacity model
   input  wire logic [1:0] cart,       // Installed cartridge grade
   input  wire logic [7:0] code,       // Selected explicit density
   output logic      [7:0] impl_code,  // Implicit write choice
   output logic            impl_bad,   // Cartridge illegal for implicit write
   output logic            model_bad,  // Explicit code not allowed on this model
   output logic            cart_bad    // Cartridge cannot hold explicit code
);
   logic hi_code;
   logic lo_code;

   assign hi_code = (code == tdl_pkg::DENS_F3) || (code == tdl_pkg::DENS_F4);
   assign lo_code = (code == tdl_pkg::DENS_F1) || (code == tdl_pkg::DENS_F2);

   always_comb begin
      impl_bad  = 1'b0;
      impl_code = tdl_pkg::DENS_F2;
      if (model == tdl_pkg::MDL_HIGH || model == tdl_pkg::MDL_MID) begin
         impl_bad  = (cart == tdl_pkg::CART_LOW);
         impl_code = (model == tdl_pkg::MDL_HIGH && cart == tdl_pkg::CART_EXT) ?
                     tdl_pkg::DENS_F4 : tdl_pkg::DENS_F3;
      end
   end

   assign model_bad = (model == tdl_pkg::MDL_LOW) ? hi_code : lo_code;
   assign cart_bad  = (cart == tdl_pkg::CART_LOW && hi_code) ||
                      (cart == tdl_pkg::CART_STD && code == tdl_pkg::DENS_F4);
endmodule // tdl_dens_chk

// >>> logic/tdl_pkg.sv
// Constants, register map and helper functions for the density and load command block
package tdl_pkg;
   // Density codes in ascending capacity
   localparam logic [7:0] DENS_IMPL = 8'h00;
   localparam logic [7:0] DENS_F1   = 8'h04;
   localparam logic [7:0] DENS_F2   = 8'h05;
   localparam logic [7:0] DENS_F3   = 8'h0f;
   localparam logic [7:0] DENS_F4   = 8'h10;
   // Opcodes decoded from the command block
   localparam logic [7:0] OPC_LOAD   = 8'h1b;
   localparam logic [7:0] OPC_MSENSE = 8'h1a;
   // Status bytes and sense keys
   localparam logic [7:0] ST_GOOD  = 8'h00;
   localparam logic [7:0] ST_CHECK = 8'h02;
   localparam logic [7:0] ST_BUSY  = 8'h08;
   localparam logic [3:0] SK_NONE  = 4'h0;
   localparam logic [3:0] SK_HW    = 4'h4;
   localparam logic [3:0] SK_ILL   = 4'h5;
   localparam logic [3:0] SK_UA    = 4'h6;
   localparam logic [3:0] SK_WP    = 4'h7;
   localparam logic [3:0] SK_BLANK = 4'h8;
   // Register byte offsets
   localparam logic [7:0] A_CDB_LO = 8'h00;
   localparam logic [7:0] A_CDB_HI = 8'h04;
   localparam logic [7:0] A_CMD    = 8'h08;
   localparam logic [7:0] A_STAT   = 8'h0c;
   localparam logic [7:0] A_DENS   = 8'h10;
   localparam logic [7:0] A_DESC0  = 8'h14;
   localparam logic [7:0] A_DESC1  = 8'h18;
   localparam logic [7:0] A_STATE  = 8'h1c;
   // Command block bit positions (low word holds bytes 0..3, high word bytes 4..5)
   localparam int B_EARLY = 8;
   localparam int B_RETENSION_REQUEST = 1;
   localparam int B_LDSEL = 0;
   localparam int B_LINK  = 8;
   // Block descriptor words: bytes 4..7 read as 00h 00h 02h 00h
   localparam logic [23:0] NBLK_ZERO = 24'h000000;
   localparam logic [31:0] DESC1_VAL = 32'h00020000;
   // Drive model and cartridge grade encodings
   localparam logic [1:0] MDL_LOW  = 2'h0;
   localparam logic [1:0] MDL_MID  = 2'h1;
   localparam logic [1:0] MDL_HIGH = 2'h2;
   localparam logic [1:0] CART_LOW = 2'h0;
   localparam logic [1:0] CART_STD = 2'h1;
   localparam logic [1:0] CART_EXT = 2'h2;
   // Reset values
   localparam logic       UA_RST   = 1'b1;
   localparam logic [7:0] DENS_RST = 8'h00;

   typedef enum logic [1:0] {OP_CDB, OP_READ, OP_WRITE, OP_MSEL} tdl_op_t;

   function automatic logic dens_known(input logic [7:0] c);
      dens_known = (c == DENS_IMPL) || (c == DENS_F1) || (c == DENS_F2) ||
                   (c == DENS_F3) || (c == DENS_F4);
   endfunction

   // Format search order, highest capacity first
   function automatic logic [7:0] search_code(input logic [1:0] i);
      unique case (i)
         2'h0:    search_code = DENS_F4;
         2'h1:    search_code = DENS_F3;
         2'h2:    search_code = DENS_F2;
         default: search_code = DENS_F1;
      endcase
   endfunction
endpackage

// >>> logic/tdl_pos_seq.sv
// Tape positioning sequencer: rewind, or retension BOT-EOT-BOT
`timescale 1ns/1ps
module tdl_pos_seq (
   input  wire logic clk_sys,    // System clock
   input  wire logic rst,        // Async reset, active high
   input  wire logic start,      // Begin a positioning pass
   input  wire logic retension_request,      // Retension requested
   input  wire logic move_done,  // Current move finished
   output logic      move_req,   // Move in progress
   output logic      move_eot,   // Target is end of tape
   output logic      done        // Pass complete, tape at BOT
);
   typedef enum logic [1:0] {P_IDLE, P_TOBOT, P_TOEOT, P_BACK} tdl_pst_t;
   typedef struct packed {
      tdl_pst_t st;
      logic     req;
      logic     eot;
      logic     retension_request;
      logic     done;
   } tdl_pseq_t;

   tdl_pseq_t q, n;

   always_comb begin
      n      = q;
      n.done = 1'b0;
      unique case (q.st)
         P_IDLE: if (start) begin
            n.st    = P_TOBOT;
            n.req   = 1'b1;
            n.eot   = 1'b0;
            n.retension_request = retension_request;
         end
         P_TOBOT: if (move_done) begin
            if (q.retension_request) begin
               n.st  = P_TOEOT;
               n.eot = 1'b1;
            end else begin
               n.st   = P_IDLE;
               n.req  = 1'b0;
               n.done = 1'b1;
            end
         end
         P_TOEOT: if (move_done) begin
            n.st  = P_BACK;
            n.eot = 1'b0;
         end
         P_BACK: if (move_done) begin
            n.st   = P_IDLE;
            n.req  = 1'b0;
            n.done = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= '{P_IDLE, 1'b0, 1'b0, 1'b0, 1'b0};
      end else begin
         q <= n;
      end
   end

   assign move_req = q.req;
   assign move_eot = q.eot;
   assign done     = q.done;

   sequence s_first_bot;
      q.st == P_TOBOT && move_done && q.retension_request;
   endsequence
   sequence s_at_eot;
      q.st == P_TOEOT && move_done;
   endsequence

   chk_retension_request_eot: assert property (@(posedge clk_sys) disable iff (rst)
      s_first_bot |=> move_eot && move_req && !done)
      else $error("retension did not head for end of tape");
   chk_retension_request_back: assert property (@(posedge clk_sys) disable iff (rst)
      s_at_eot |=> !move_eot && move_req && !done)
      else $error("retension did not return to BOT");
endmodule // tdl_pos_seq

// >>> test/tb_tape_density_and_load_cmds.sv
// Self-checking bench for the density and load command block
`timescale 1ns/1ps
module tb_tape_density_and_load_cmds;
   logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        cart_removed = 1'b0, parity_err = 1'b0, want = 1'b0;
   logic        pready, pslverr, probe_req, probe_done, probe_hit;
   logic        move_req, move_eot, move_done, panel_led;
   logic [7:0]  paddr = 8'h00, tape_fmt = 8'h00, probe_code;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd10;
   logic [1:0]  drive_model = 2'h0, cart_type = 2'h0;
   logic [3:0]  lat = 4'h2;
   logic [2:0]  eotv;
   logic [32:0] expq[$];
   logic [7:0]  pcq[$];
   int          n_mismatch = 0, checked = 0, legs = 0;
   always #2 clk_sys = ~clk_sys;
   tdl_cmd_core i_dut (.*);
   tdl_tape_model i_tape (.*);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Read results are compared against the oldest note
   always @(posedge clk_sys) begin
      if (want && psel && penable && pready) chk("read", {pslverr, prdata}, expq.pop_front());
      if (move_done) begin
         eotv = {eotv[1:0], move_eot};
         legs++;
      end
      if (probe_done) pcq.push_back(probe_code);
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic c, input logic [32:0] e);
      if (c) expq.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      want <= c;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      want <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 1'b1, {1'b0, e});
   endtask
   task automatic cmd(input logic [1:0] op, input logic [31:0] lo, hi, st);
      bus(1'b1, tdl_pkg::A_CDB_LO, lo, 1'b0, 33'h0);
      bus(1'b1, tdl_pkg::A_CDB_HI, hi, 1'b0, 33'h0);
      bus(1'b1, tdl_pkg::A_CMD, {30'h0, op}, 1'b0, 33'h0);
      rd = 32'h0;
      while (rd[16] !== 1'b1) bus(1'b0, tdl_pkg::A_STAT, 32'h0, 1'b0, 33'h0);
      rdc(tdl_pkg::A_STAT, st);
   endtask
   task automatic dens(input logic [7:0] c, input logic [31:0] st);
      bus(1'b1, tdl_pkg::A_DENS, {24'h0, c}, 1'b0, 33'h0);
      cmd(2'h3, 32'h0, 32'h0, st);
   endtask
   task automatic pull_cart();
      cart_removed <= 1'b1;
      @(posedge clk_sys);
      cart_removed <= 1'b0;
      @(posedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      n_mismatch++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rdc(tdl_pkg::A_DESC1, tdl_pkg::DESC1_VAL);
      rdc(tdl_pkg::A_DESC0, 32'h0);
      bus(1'b0, 8'h20, 32'h0, 1'b1, {1'b1, 32'h0});
      parity_err <= 1'b1;
      cmd(2'h0, 32'h1a, 32'h0, 32'h10402);
      parity_err <= 1'b0;
      cmd(2'h0, 32'h21a, 32'h0, 32'h10502);
      cmd(2'h0, 32'h1a, xs() & 32'hff, 32'h10602);
      cmd(2'h0, 32'h11b, 32'h100, 32'h10502);
      lat <= 4'h2 + 4'(xs() % 6);
      legs = 0;
      cmd(2'h0, 32'h1b, 32'h3, 32'h10000);
      chk("legs", legs, 3);
      chk("leg order", eotv, 3'b010);
      chk("led", panel_led, 1'b1);
      lat <= 4'h8;
      cmd(2'h0, 32'h11b, 32'h2, 32'h10000);
      chk("moving", move_req, 1'b1);
      cmd(2'h0, 32'h1a, 32'h0, 32'h10008);
      while (move_req) @(posedge clk_sys);
      repeat (2) @(posedge clk_sys);
      chk("led", panel_led, 1'b0);
      pull_cart();
      cmd(2'h0, 32'h1a, 32'h0, 32'h10000);
      cmd(2'h0, 32'h1b, 32'h1, 32'h10000);
      pull_cart();
      cmd(2'h0, 32'h1a, 32'h0, 32'h10602);
      dens(8'h0f, 32'h10000);
      rdc(tdl_pkg::A_DESC0, 32'h0);
      tape_fmt <= 8'h0f;
      cmd(2'h1, 32'h0, 32'h0, 32'h10000);
      rdc(tdl_pkg::A_DESC0, 32'h0f);
      tape_fmt <= 8'h10;
      cmd(2'h1, 32'h0, 32'h0, 32'h10802);
      dens(8'h00, 32'h10000);
      tape_fmt <= 8'h05;
      pcq.delete();
      cmd(2'h1, 32'h0, 32'h0, 32'h10000);
      chk("probe order", {pcq[0], pcq[1], pcq[2]}, 24'h100f05);
      rdc(tdl_pkg::A_DESC0, 32'h05);
      drive_model <= tdl_pkg::MDL_HIGH;
      cart_type <= tdl_pkg::CART_EXT;
      dens(8'h00, 32'h10000);
      cmd(2'h2, 32'h0, 32'h0, 32'h10000);
      rdc(tdl_pkg::A_DESC0, 32'h10);
      cart_type <= tdl_pkg::CART_LOW;
      dens(8'h00, 32'h10000);
      cmd(2'h2, 32'h0, 32'h0, 32'h10502);
      dens(8'h04, 32'h10000);
      cmd(2'h2, 32'h0, 32'h0, 32'h10502);
      cart_type <= tdl_pkg::CART_STD;
      dens(8'h10, 32'h10000);
      cmd(2'h2, 32'h0, 32'h0, 32'h10702);
      dens(8'h07, 32'h10502);
      chk("notes left", expq.size(), 0);
      test_done();
   end
endmodule // tb_tape_density_and_load_cmds

// >>> test/tdl_tape_model.sv
// Tape transport model answering moves and format probes
`timescale 1ns/1ps
module tdl_tape_model (
   input  wire logic       clk_sys,    // System clock
   input  wire logic       rst,        // Async reset
   input  wire logic [3:0] lat,        // Cycles per leg or probe
   input  wire logic [7:0] tape_fmt,   // Format on the tape
   input  wire logic       move_req,   // Move in progress
   input  wire logic       probe_req,  // Probe in progress
   input  wire logic [7:0] probe_code, // Format probed
   output logic            move_done,  // Leg finished
   output logic            probe_done, // Probe finished
   output logic            probe_hit   // Probe matched
);
   logic [3:0] cnt_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q      <= 4'h0;
         move_done  <= 1'b0;
         probe_done <= 1'b0;
         probe_hit  <= 1'b0;
      end else begin
         cnt_q      <= (move_done | probe_done | ~(move_req | probe_req)) ? 4'h0 : cnt_q + 4'h1;
         move_done  <= move_req & (cnt_q == lat);
         probe_done <= probe_req & (cnt_q == lat);
         // Hit is only meaningful with done; it toggles while no probe is in progress
         probe_hit  <= probe_req ? (probe_code == tape_fmt) : ~probe_hit;
      end
   end
endmodule // tdl_tape_model
